// file: src/mpp_pkg.sv
/*
 constants for the phy management poller: register map, fields, frame and timing.
 assumes a 40 mhz system clock and axi4-lite register access.
*/
package mpp_pkg;
    localparam logic [31:0] ADDR_VERSION = 32'h01c83800;
    localparam logic [31:0] ADDR_CONTROL = 32'h01c83804;
    localparam logic [31:0] ADDR_ALIVE = 32'h01c83808;
    localparam logic [31:0] ADDR_LINK = 32'h01c8380c;
    localparam logic [31:0] ADDR_LNK_RAW = 32'h01c83810;
    localparam logic [31:0] ADDR_LNK_MSK = 32'h01c83814;
    localparam logic [31:0] ADDR_USR_RAW = 32'h01c83818;
    localparam logic [31:0] ADDR_USR_MSK = 32'h01c8381c;
    localparam logic [31:0] ADDR_MASK_SET = 32'h01c83820;
    localparam logic [31:0] ADDR_MASK_CLR = 32'h01c83824;
    localparam logic [31:0] ADDR_ACC_A = 32'h01c83828;
    localparam logic [31:0] ADDR_ACC_B = 32'h01c8382c;
    localparam logic [31:0] ADDR_SEL_A = 32'h01c83830;
    localparam logic [31:0] ADDR_SEL_B = 32'h01c83834;
    localparam logic [31:0] CTL_RST = 32'h40000000;
    localparam int CTL_EN_BIT = 30;
    localparam int ACC_GO_BIT = 31;
    localparam int ACC_WR_BIT = 30;
    localparam int ACC_ACK_BIT = 29;
    localparam int ACC_REG_LSB = 21;
    localparam int ACC_PHY_LSB = 16;
    localparam int SEL_LINKEN_BIT = 6;
    localparam logic [4:0] STATUS_REG = 5'h01;
    localparam int LINK_BIT = 2;
    localparam int CLK_NS = 25;
    localparam int MDC_MIN_NS = 400;
    localparam int MDC_HALF_CYC = (MDC_MIN_NS / 2 + CLK_NS - 1) / CLK_NS;
    localparam int FRAME_BITS = 64;
    localparam int DRIVE_BITS_RD = 46;
    localparam int TA_ACK_BIT = 47;
    localparam logic [31:0] PREAMBLE = 32'hffffffff;
    localparam logic [1:0] SOF = 2'h1;
    localparam logic [1:0] OP_RD = 2'h2;
    localparam logic [1:0] OP_WR = 2'h1;
    localparam logic [1:0] TA_WR = 2'h2;
    localparam logic [1:0] RESP_OK = 2'h0;
    localparam logic [1:0] RESP_ERR = 2'h2;
endpackage

// file: src/mpp_frame.sv
/*
 one management frame engine: makes the management clock and shifts a frame.
 assumes start and its fields hold while busy is low and that mdio_in is already
 synchronised to clk_in.
*/
`timescale 1ns/1ps
module mpp_frame #(
    parameter int HALF = mpp_pkg::MDC_HALF_CYC
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic ce_in,
    input wire logic start_in,
    input wire logic wr_in,
    input wire logic [4:0] phy_in,
    input wire logic [4:0] reg_in,
    input wire logic [15:0] wdata_in,
    input wire logic mdio_in,
    output logic busy_out,
    output logic done_out,
    output logic ack_out,
    output logic [15:0] rdata_out,
    output logic mdc_out,
    output logic mdio_out,
    output logic mdio_oe_n_out
);
    logic [7:0] ph_r;
    logic [5:0] bit_r;
    logic [63:0] sh_r;
    logic wr_r;
    logic tick;
    assign tick = busy_out && (ph_r == 8'(HALF - 1));

    // clock divider and bit sequencer; data moves on the falling edge
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            busy_out <= 1'b0;
            done_out <= 1'b0;
            ph_r <= 8'h00;
            bit_r <= 6'h00;
            sh_r <= 64'h0;
            wr_r <= 1'b0;
            mdc_out <= 1'b0;
            mdio_out <= 1'b1;
            mdio_oe_n_out <= 1'b1;
        end else if (ce_in) begin
            done_out <= 1'b0;
            if (!busy_out) begin
                if (start_in) begin
                    busy_out <= 1'b1;
                    wr_r <= wr_in;
                    bit_r <= 6'h00;
                    ph_r <= 8'h00;
                    mdc_out <= 1'b0;
                    sh_r <= {mpp_pkg::PREAMBLE, mpp_pkg::SOF,
                        wr_in ? mpp_pkg::OP_WR : mpp_pkg::OP_RD,
                        phy_in, reg_in, mpp_pkg::TA_WR, wdata_in};
                    mdio_out <= 1'b1;
                    mdio_oe_n_out <= 1'b0;
                end
            end else if (!tick) begin
                ph_r <= ph_r + 8'h01;
            end else begin
                ph_r <= 8'h00;
                mdc_out <= !mdc_out;
                if (mdc_out) begin
                    if (bit_r == 6'(mpp_pkg::FRAME_BITS - 1)) begin
                        busy_out <= 1'b0;
                        done_out <= 1'b1;
                        mdio_oe_n_out <= 1'b1;
                        mdio_out <= 1'b1;
                    end else begin
                        bit_r <= bit_r + 6'h01;
                        sh_r <= {sh_r[62:0], 1'b0};
                        mdio_out <= sh_r[62];
                        // reads hand the bus to the phy at turnaround
                        mdio_oe_n_out <= !wr_r &&
                            (bit_r >= 6'(mpp_pkg::DRIVE_BITS_RD - 1));
                    end
                end
            end
        end
    end

    // read capture at the end of each bit, just before the fall; writes count as acknowledged.
    // the pin synchroniser lags four clocks, too late for the rising edge at short half periods
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ack_out <= 1'b0;
            rdata_out <= 16'h0000;
        end else if (ce_in) begin
            if (!busy_out && start_in) begin
                ack_out <= wr_in;
            end else if (tick && mdc_out && !wr_r) begin
                if (bit_r == 6'(mpp_pkg::TA_ACK_BIT)) begin
                    ack_out <= !mdio_in;
                end else if (bit_r > 6'(mpp_pkg::TA_ACK_BIT)) begin
                    rdata_out <= {rdata_out[14:0], mdio_in};
                end
            end
        end
    end

    sequence s_go;
        ce_in && start_in && !busy_out;
    endsequence
    a_frame_opens: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        s_go |=> busy_out && !mdio_oe_n_out && mdio_out && !mdc_out && bit_r == 6'h00)
        else $error("frame did not open with a driven preamble one");
    a_read_release: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        busy_out && !wr_r && bit_r >= 6'(mpp_pkg::DRIVE_BITS_RD) |-> mdio_oe_n_out)
        else $error("bus still driven during read turnaround or data");
    a_mdc_pace: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        $changed(mdc_out) && busy_out |-> $past(ph_r) == 8'(HALF - 1))
        else $error("management clock phase shorter than the minimum");
endmodule

// file: src/mpp_top.sv
/*
 phy management poller: axi4-lite registers, address poller, user commands.
 assumes one master with one write and one read in flight, and ce_in high
 whenever the bus is active.
*/
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/1ps
module mpp_top #(
    parameter logic [31:0] VERSION_ID = 32'h00010000, // arbitrary value
    parameter int HALF = mpp_pkg::MDC_HALF_CYC
) (
    input wire logic ref_clk_in,
    input wire logic arst_n_in,
    input wire logic ce_in,
    input wire logic [31:0] s_axi_awaddr_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    output logic [1:0] s_axi_bresp_out,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    input wire logic [31:0] s_axi_araddr_in,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    output logic mdc_out,
    input wire logic mdio_in,
    output logic mdio_out,
    output logic mdio_oe_n_out
);
    typedef enum logic [0:0] {PL_IDLE, PL_WAIT} mpp_poll_t;

    logic rst_q1_r;
    logic rst_n_s;
    logic m1_r;
    logic m2_r;
    logic m3_r;
    logic mdio_f_r;
    logic aw_held_r;
    logic w_held_r;
    logic [31:0] aw_addr_r;
    logic [31:0] w_data_r;
    logic [31:0] w_mask_r;
    logic [31:0] lane_mask;
    logic do_write;
    logic [31:0] wv;
    logic w_mapped;
    logic [31:0] rd_mux;
    logic rd_mapped;
    logic [31:0] ctl_r;
    logic [31:0] alive_r;
    logic [31:0] link_r;
    logic [31:0] acc_r;
    logic [31:0] sel_r;
    logic lnk_raw_r;
    logic usr_raw_r;
    logic usr_mask_r;
    logic [4:0] poll_phy_r;
    mpp_poll_t st_r;
    logic cur_user_r;
    logic fr_busy;
    logic fr_done;
    logic fr_ack;
    logic [15:0] fr_rdata;
    logic fr_start;
    logic use_user;
    logic poll_done;
    logic user_done;
    logic new_link;
    logic lnk_evt;

    // reset release through two flops
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rst_q1_r <= 1'b0;
            rst_n_s <= 1'b0;
        end else begin
            rst_q1_r <= 1'b1;
            rst_n_s <= rst_q1_r;
        end
    end

    // pin synchroniser; the filtered level moves only when stages two and three agree
    always_ff @(posedge ref_clk_in or negedge rst_n_s) begin
        if (!rst_n_s) begin
            m1_r <= 1'b1;
            m2_r <= 1'b1;
            m3_r <= 1'b1;
            mdio_f_r <= 1'b1;
        end else if (ce_in) begin
            m1_r <= mdio_in;
            m2_r <= m1_r;
            m3_r <= m2_r;
            if (m2_r == m3_r) begin
                mdio_f_r <= m3_r;
            end
        end
    end

    for (genvar g = 0; g < 4; g++) begin : g_lane
        assign lane_mask[8*g +: 8] = {8{s_axi_wstrb_in[g]}};
    end

    assign do_write = ce_in && aw_held_r && w_held_r && !s_axi_bvalid_out;
    assign wv = w_data_r & w_mask_r;

    // axi write channels, taken in either order
    always_ff @(posedge ref_clk_in or negedge rst_n_s) begin
        if (!rst_n_s) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            aw_addr_r <= 32'h0;
            w_data_r <= 32'h0;
            w_mask_r <= 32'h0;
            s_axi_awready_out <= 1'b0;
            s_axi_wready_out <= 1'b0;
            s_axi_bvalid_out <= 1'b0;
            s_axi_bresp_out <= mpp_pkg::RESP_OK;
        end else if (ce_in) begin
            if (s_axi_awvalid_in && s_axi_awready_out) begin
                aw_held_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr_in;
                s_axi_awready_out <= 1'b0;
            end else if (!aw_held_r && !s_axi_bvalid_out) begin
                s_axi_awready_out <= 1'b1;
            end
            if (s_axi_wvalid_in && s_axi_wready_out) begin
                w_held_r <= 1'b1;
                w_data_r <= s_axi_wdata_in;
                w_mask_r <= lane_mask;
                s_axi_wready_out <= 1'b0;
            end else if (!w_held_r && !s_axi_bvalid_out) begin
                s_axi_wready_out <= 1'b1;
            end
            if (do_write) begin
                aw_held_r <= 1'b0;
                w_held_r <= 1'b0;
                s_axi_bvalid_out <= 1'b1;
                s_axi_bresp_out <= w_mapped ? mpp_pkg::RESP_OK : mpp_pkg::RESP_ERR;
            end else if (s_axi_bvalid_out && s_axi_bready_in) begin
                s_axi_bvalid_out <= 1'b0;
            end
        end
    end

    always_comb begin
        unique case (aw_addr_r)
            mpp_pkg::ADDR_VERSION, mpp_pkg::ADDR_CONTROL, mpp_pkg::ADDR_ALIVE,
            mpp_pkg::ADDR_LINK, mpp_pkg::ADDR_LNK_RAW, mpp_pkg::ADDR_LNK_MSK,
            mpp_pkg::ADDR_USR_RAW, mpp_pkg::ADDR_USR_MSK, mpp_pkg::ADDR_MASK_SET,
            mpp_pkg::ADDR_MASK_CLR, mpp_pkg::ADDR_ACC_A, mpp_pkg::ADDR_ACC_B,
            mpp_pkg::ADDR_SEL_A, mpp_pkg::ADDR_SEL_B: w_mapped = 1'b1;
            default: w_mapped = 1'b0;
        endcase
    end

    // read view; second-instance fields and registers read as zero
    always_comb begin
        rd_mapped = 1'b1;
        unique case (s_axi_araddr_in)
            mpp_pkg::ADDR_VERSION: rd_mux = VERSION_ID;
            mpp_pkg::ADDR_CONTROL: rd_mux = ctl_r;
            mpp_pkg::ADDR_ALIVE: rd_mux = alive_r;
            mpp_pkg::ADDR_LINK: rd_mux = link_r;
            mpp_pkg::ADDR_LNK_RAW: rd_mux = {31'h0, lnk_raw_r};
            mpp_pkg::ADDR_LNK_MSK: rd_mux = {31'h0, lnk_raw_r & sel_r[mpp_pkg::SEL_LINKEN_BIT]};
            mpp_pkg::ADDR_USR_RAW: rd_mux = {31'h0, usr_raw_r};
            mpp_pkg::ADDR_USR_MSK: rd_mux = {31'h0, usr_raw_r & usr_mask_r};
            mpp_pkg::ADDR_MASK_SET: rd_mux = {31'h0, usr_mask_r};
            mpp_pkg::ADDR_MASK_CLR: rd_mux = {31'h0, usr_mask_r};
            mpp_pkg::ADDR_ACC_A: rd_mux = acc_r;
            mpp_pkg::ADDR_SEL_A: rd_mux = sel_r;
            mpp_pkg::ADDR_ACC_B, mpp_pkg::ADDR_SEL_B: rd_mux = 32'h0;
            default: begin
                rd_mux = 32'h0;
                rd_mapped = 1'b0;
            end
        endcase
    end

    // axi read channel, one cycle to rvalid
    always_ff @(posedge ref_clk_in or negedge rst_n_s) begin
        if (!rst_n_s) begin
            s_axi_arready_out <= 1'b0;
            s_axi_rvalid_out <= 1'b0;
            s_axi_rdata_out <= 32'h0;
            s_axi_rresp_out <= mpp_pkg::RESP_OK;
        end else if (ce_in) begin
            if (s_axi_arvalid_in && s_axi_arready_out) begin
                s_axi_arready_out <= 1'b0;
                s_axi_rvalid_out <= 1'b1;
                s_axi_rdata_out <= rd_mux;
                s_axi_rresp_out <= rd_mapped ? mpp_pkg::RESP_OK : mpp_pkg::RESP_ERR;
            end else if (s_axi_rvalid_out && s_axi_rready_in) begin
                s_axi_rvalid_out <= 1'b0;
            end else if (!s_axi_rvalid_out) begin
                s_axi_arready_out <= 1'b1;
            end
        end
    end

    // control, phy select and user access; access writes are refused while go is set
    always_ff @(posedge ref_clk_in or negedge rst_n_s) begin
        if (!rst_n_s) begin
            ctl_r <= mpp_pkg::CTL_RST;
            sel_r <= 32'h0;
            acc_r <= 32'h0;
        end else if (ce_in) begin
            if (do_write && aw_addr_r == mpp_pkg::ADDR_CONTROL) begin
                ctl_r <= (ctl_r & ~w_mask_r) | wv;
            end
            if (do_write && aw_addr_r == mpp_pkg::ADDR_SEL_A) begin
                sel_r <= (sel_r & ~w_mask_r) | wv;
            end
            if (user_done) begin
                acc_r[mpp_pkg::ACC_GO_BIT] <= 1'b0;
                acc_r[mpp_pkg::ACC_ACK_BIT] <= fr_ack;
                if (!acc_r[mpp_pkg::ACC_WR_BIT]) begin
                    acc_r[15:0] <= fr_rdata;
                end
            end else if (do_write && aw_addr_r == mpp_pkg::ADDR_ACC_A &&
                    !acc_r[mpp_pkg::ACC_GO_BIT]) begin
                acc_r <= (acc_r & ~w_mask_r) | wv;
            end
        end
    end

    // event flags: hardware set wins over a software clear in the same cycle
    always_ff @(posedge ref_clk_in or negedge rst_n_s) begin
        if (!rst_n_s) begin
            lnk_raw_r <= 1'b0;
            usr_raw_r <= 1'b0;
            usr_mask_r <= 1'b0;
        end else if (ce_in) begin
            if (lnk_evt) begin
                lnk_raw_r <= 1'b1;
            end else if (do_write && wv[0] && (aw_addr_r == mpp_pkg::ADDR_LNK_RAW ||
                    aw_addr_r == mpp_pkg::ADDR_LNK_MSK)) begin
                lnk_raw_r <= 1'b0;
            end
            if (user_done) begin
                usr_raw_r <= 1'b1;
            end else if (do_write && wv[0] && (aw_addr_r == mpp_pkg::ADDR_USR_RAW ||
                    aw_addr_r == mpp_pkg::ADDR_USR_MSK)) begin
                usr_raw_r <= 1'b0;
            end
            if (do_write && wv[0] && aw_addr_r == mpp_pkg::ADDR_MASK_SET) begin
                usr_mask_r <= 1'b1;
            end else if (do_write && wv[0] && aw_addr_r == mpp_pkg::ADDR_MASK_CLR) begin
                usr_mask_r <= 1'b0;
            end
        end
    end

    // user commands go ahead of polling so software waits at most one frame
    assign use_user = acc_r[mpp_pkg::ACC_GO_BIT];
    assign fr_start = (st_r == PL_IDLE) && !fr_busy &&
        (ctl_r[mpp_pkg::CTL_EN_BIT] || use_user);
    assign poll_done = (st_r == PL_WAIT) && fr_done && !cur_user_r;
    assign user_done = ce_in && (st_r == PL_WAIT) && fr_done && cur_user_r;
    assign new_link = fr_ack && fr_rdata[mpp_pkg::LINK_BIT];
    assign lnk_evt = ce_in && poll_done && sel_r[mpp_pkg::SEL_LINKEN_BIT] &&
        (poll_phy_r == sel_r[4:0]) && (new_link != link_r[poll_phy_r]);

    always_ff @(posedge ref_clk_in or negedge rst_n_s) begin
        if (!rst_n_s) begin
            st_r <= PL_IDLE;
            cur_user_r <= 1'b0;
        end else if (ce_in) begin
            unique case (st_r)
                PL_IDLE: begin
                    if (fr_start) begin
                        st_r <= PL_WAIT;
                        cur_user_r <= use_user;
                    end
                end
                PL_WAIT: begin
                    if (fr_done) begin
                        st_r <= PL_IDLE;
                    end
                end
            endcase
        end
    end

    // address walk and per-phy status
    always_ff @(posedge ref_clk_in or negedge rst_n_s) begin
        if (!rst_n_s) begin
            poll_phy_r <= 5'h00;
            alive_r <= 32'h0;
            link_r <= 32'h0;
        end else if (ce_in && poll_done) begin
            poll_phy_r <= poll_phy_r + 5'h01;
            alive_r[poll_phy_r] <= fr_ack;
            link_r[poll_phy_r] <= new_link;
        end
    end

    mpp_frame #(
        .HALF(HALF)
    ) u_frame (
        .clk_in(ref_clk_in),
        .rst_n_in(rst_n_s),
        .ce_in(ce_in),
        .start_in(fr_start),
        .wr_in(use_user && acc_r[mpp_pkg::ACC_WR_BIT]),
        .phy_in(use_user ? acc_r[mpp_pkg::ACC_PHY_LSB +: 5] : poll_phy_r),
        .reg_in(use_user ? acc_r[mpp_pkg::ACC_REG_LSB +: 5] : mpp_pkg::STATUS_REG),
        .wdata_in(acc_r[15:0]),
        .mdio_in(mdio_f_r),
        .busy_out(fr_busy),
        .done_out(fr_done),
        .ack_out(fr_ack),
        .rdata_out(fr_rdata),
        .mdc_out(mdc_out),
        .mdio_out(mdio_out),
        .mdio_oe_n_out(mdio_oe_n_out)
    );

    a_poll_wrap: assert property (@(posedge ref_clk_in) disable iff (!rst_n_s)
        ce_in && poll_done && poll_phy_r == 5'h1f |=> poll_phy_r == 5'h00)
        else $error("poll address did not wrap to zero");
    a_poll_step: assert property (@(posedge ref_clk_in) disable iff (!rst_n_s)
        ce_in && poll_done |=> poll_phy_r == $past(poll_phy_r) + 5'h01)
        else $error("poll address did not advance");
    a_alive_bit: assert property (@(posedge ref_clk_in) disable iff (!rst_n_s)
        ce_in && poll_done |=> alive_r[$past(poll_phy_r)] == $past(fr_ack))
        else $error("alive bit does not follow the poll answer");
    a_link_cause: assert property (@(posedge ref_clk_in) disable iff (!rst_n_s)
        $rose(lnk_raw_r) |-> $past(lnk_evt))
        else $error("link change flag set without a link change");
    a_link_catch: assert property (@(posedge ref_clk_in) disable iff (!rst_n_s)
        lnk_evt |=> lnk_raw_r)
        else $error("link change event lost");
    a_user_done: assert property (@(posedge ref_clk_in) disable iff (!rst_n_s)
        user_done |=> usr_raw_r && !acc_r[mpp_pkg::ACC_GO_BIT])
        else $error("user command completion not flagged");
    a_mask_set: assert property (@(posedge ref_clk_in) disable iff (!rst_n_s)
        do_write && wv[0] && aw_addr_r == mpp_pkg::ADDR_MASK_SET |=> usr_mask_r)
        else $error("mask set write did not enable the event");
    a_mask_clear: assert property (@(posedge ref_clk_in) disable iff (!rst_n_s)
        do_write && wv[0] && aw_addr_r == mpp_pkg::ADDR_MASK_CLR |=> !usr_mask_r)
        else $error("mask clear write did not disable the event");
    a_user_clear: assert property (@(posedge ref_clk_in) disable iff (!rst_n_s)
        do_write && wv[0] && aw_addr_r == mpp_pkg::ADDR_USR_RAW && !user_done |=> !usr_raw_r)
        else $error("command done flag not cleared by a write of one");
endmodule

// file: test/mpp_phy_model.sv
/*
 behavioural phy set on the shared management bus.
 assumes the bench resolves the data wire with a pull-up.
*/
`timescale 1ns/1ps
module mpp_phy_model (
    input wire logic mdc_in,
    input wire logic oe_n_in,
    input wire logic mdio_in,
    input wire logic [31:0] present_in,
    input wire logic [31:0] link_in,
    output logic drv_out,
    output logic bit_out,
    output logic [25:0] last_wr_out
);
    int k;
    logic arm;
    logic [63:0] sh;
    logic [15:0] rd;
    logic [15:0] mem [0:1023];
    initial begin
        drv_out = 0;
        bit_out = 1;
        arm = 0;
        k = 0;
        last_wr_out = '0;
        for (int i = 0; i < 1024; i++) mem[i] = 16'h0000;
    end
    always @(negedge oe_n_in) begin
        k = 0;
        arm = 0;
    end
    // answers only a well formed frame to its own address
    always @(posedge mdc_in) begin
        sh = {sh[62:0], mdio_in};
        if (k == 45 && sh[45:12] == {32'hffffffff, 2'h1} && sh[11:10] == 2'h2
            && present_in[sh[9:5]]) begin
            rd = (sh[4:0] == 5'h01) ? {13'h0000, link_in[sh[9:5]], 2'h0} : mem[sh[9:0]];
            arm = 1;
        end
        if (k == 63 && sh[63:30] == {32'hffffffff, 2'h1} && sh[29:28] == 2'h1
            && present_in[sh[27:23]]) begin
            mem[sh[27:18]] = sh[15:0];
            last_wr_out = {sh[27:18], sh[15:0]};
        end
        k++;
    end
    // ack low then data msb first, released after the last bit
    always @(negedge mdc_in) begin
        if (arm && k >= 47 && k <= 63) begin
            drv_out = 1;
            bit_out = (k == 47) ? 1'b0 : rd[63 - k];
        end else begin
            drv_out = 0;
            arm = arm && k < 64;
        end
    end
endmodule

// file: test/mpp_top_tb.sv
/*
 self-checking bench for mpp_top: axi4-lite master, phy model, sweep checks.
 assumes a half period of 4 clocks, so one address sweep takes about 16.5k clocks.
*/
`timescale 1ns/1ps
module mpp_top_tb;
    localparam logic [31:0] VER = 32'h00a50001; // arbitrary value
    logic clk = 0;
    logic rst_n = 0;
    logic [31:0] awaddr, wdata, araddr, rdata, present, link, seed, acc, got;
    logic awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid;
    logic arready, rvalid, mdc, mdo, oen, drv, pb;
    logic [1:0] bresp, rresp, rr;
    logic [25:0] last_wr;
    wire mdio = !oen ? mdo : (drv ? pb : 1'b1);
    int failures = 0;
    int n_compared = 0;
    always #12.5 clk = ~clk;
    mpp_top #(.VERSION_ID(VER), .HALF(4)) mpp_top_inst (.ref_clk_in(clk), .arst_n_in(rst_n),
        .ce_in(1'b1), .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
        .s_axi_awready_out(awready), .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hf),
        .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
        .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready), .s_axi_araddr_in(araddr),
        .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
        .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
        .mdc_out(mdc), .mdio_in(mdio), .mdio_out(mdo), .mdio_oe_n_out(oen));
    mpp_phy_model mpp_phy_model_inst (.mdc_in(mdc), .oe_n_in(oen), .mdio_in(mdio),
        .present_in(present), .link_in(link), .drv_out(drv), .bit_out(pb),
        .last_wr_out(last_wr));
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            failures++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw;
        logic w;
        aw = 1;
        w = 1;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1;
        wvalid <= 1;
        while (aw || w) begin
            @(posedge clk);
            if (aw && awready === 1) begin
                aw = 0;
                awvalid <= 0;
            end
            if (w && wready === 1) begin
                w = 0;
                wvalid <= 0;
            end
        end
        bready <= 1;
        do @(posedge clk); while (bvalid !== 1);
        bready <= 0;
        chk("bresp", {30'h0, er}, {30'h0, bresp});
    endtask
    task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        do begin
            @(posedge clk);
            if (arready === 1) arvalid <= 0;
        end while (rvalid !== 1);
        d = rdata;
        r = rresp;
        // rready stays up between reads, so back-to-back calls never drop it
    endtask
    task automatic rchk(input string nm, input logic [31:0] a, input logic [31:0] e);
        rd(a, got, rr);
        chk(nm, e, got);
    endtask
    task automatic cmd(input logic [31:0] c);
        wr(mpp_pkg::ADDR_ACC_A, c, 2'h0);
        do rd(mpp_pkg::ADDR_ACC_A, got, rr); while (got[31] !== 1'b0);
    endtask
    task automatic conclude();
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        repeat (90000) @(posedge clk);
        failures++;
        conclude();
    end
    initial begin
        {awaddr, wdata, araddr, awvalid, wvalid, bready, arvalid, rready} = '0;
        seed = lfsr(32'h072e5ab9);
        present = (seed | 32'h00000028) & ~32'h00000001;
        seed = lfsr(seed);
        link = seed;
        repeat (6) @(posedge clk);
        rst_n <= 1;
        rchk("version", mpp_pkg::ADDR_VERSION, VER);
        rchk("control", mpp_pkg::ADDR_CONTROL, mpp_pkg::CTL_RST);
        wr(32'h01c83838, 32'h1, 2'h2);
        rchk("unmapped", 32'h01c83838, 32'h0);
        chk("rresp", 32'h2, {30'h0, rr});
        repeat (17000) @(posedge clk);
        rchk("alive", mpp_pkg::ADDR_ALIVE, present);
        rchk("link", mpp_pkg::ADDR_LINK, present & link);
        wr(mpp_pkg::ADDR_SEL_A, 32'h45, 2'h0);
        wr(mpp_pkg::ADDR_LNK_RAW, 32'h1, 2'h0);
        link[5] <= ~link[5];
        repeat (17000) @(posedge clk);
        rchk("lnk_raw", mpp_pkg::ADDR_LNK_RAW, 32'h1);
        rchk("lnk_msk", mpp_pkg::ADDR_LNK_MSK, 32'h1);
        rchk("link2", mpp_pkg::ADDR_LINK, present & link);
        wr(mpp_pkg::ADDR_LNK_MSK, 32'h1, 2'h0);
        rchk("lnk_clr", mpp_pkg::ADDR_LNK_RAW, 32'h0);
        seed = lfsr(seed);
        acc = {6'h30, 5'h04, 5'h03, seed[15:0]};
        cmd(acc);
        chk("wr_cmd", acc ^ 32'ha0000000, got);
        chk("phy_wr", {6'h0, 5'h03, 5'h04, seed[15:0]}, {6'h0, last_wr});
        cmd({6'h20, 5'h04, 5'h03, 16'h0000});
        chk("rd_cmd", {6'h08, 5'h04, 5'h03, seed[15:0]}, got);
        cmd({6'h20, 5'h01, 5'h00, 16'h0000});
        chk("absent", 32'h0, got & 32'ha0000000);
        wr(mpp_pkg::ADDR_MASK_CLR, 32'h1, 2'h0);
        rchk("usr_raw", mpp_pkg::ADDR_USR_RAW, 32'h1);
        rchk("usr_off", mpp_pkg::ADDR_USR_MSK, 32'h0);
        wr(mpp_pkg::ADDR_MASK_SET, 32'h1, 2'h0);
        rchk("mask", mpp_pkg::ADDR_MASK_SET, 32'h1);
        rchk("usr_on", mpp_pkg::ADDR_USR_MSK, 32'h1);
        wr(mpp_pkg::ADDR_USR_RAW, 32'h1, 2'h0);
        rchk("usr_clr", mpp_pkg::ADDR_USR_RAW, 32'h0);
        rchk("acc_b", mpp_pkg::ADDR_ACC_B, 32'h0);
        rchk("sel_b", mpp_pkg::ADDR_SEL_B, 32'h0);
        wr(mpp_pkg::ADDR_CONTROL, 32'h0, 2'h0);
        rchk("ctl_off", mpp_pkg::ADDR_CONTROL, 32'h0);
        conclude();
    end
endmodule
